// *** logic/pfh_host.sv ***
// Host controller that reads, programs and erases a parallel flash
// Behaviour
// - Sector erase selects sector by address bits nineteen down to twelve.
// - Block erase selects block by address bits nineteen down to sixteen.
// - Completion shown by toggle or inverted-data bit; host polls only toggle bit six.
// - Host drives output gate low to read, high while writing.
// - Host pulses write strobe for every write, chip select low.
`timescale 1ns/1ps
module pfh_host #(
	parameter int PROG_TOUT_CYC = pfh_pkg::PROGRAM_CYC * pfh_pkg::TIMEOUT_FACTOR,
	parameter int ERASE_TOUT_CYC = pfh_pkg::ERASE_CYC * pfh_pkg::TIMEOUT_FACTOR,
	parameter int CHIP_TOUT_CYC = pfh_pkg::CHIP_ERASE_CYC * pfh_pkg::TIMEOUT_FACTOR
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	// Request side
	input wire logic req_valid_i,
	input wire pfh_pkg::pfh_req_t req_i,
	output logic req_ready_o,
	output logic rsp_valid_o,
	output pfh_pkg::pfh_rsp_t rsp_o,
	// Flash pins
	output pfh_pkg::pfh_ctl_t ctl_o,
	output logic [pfh_pkg::ADDR_W-1:0] top_address_line_o,
	input wire logic [pfh_pkg::DATA_W-1:0] byte_lines_i,
	output logic [pfh_pkg::DATA_W-1:0] byte_lines_o,
	output logic byte_lines_oe_n_o
);
	import pfh_pkg::*;
	default clocking @(posedge ref_clk_i);
	endclocking
	default disable iff (!reset_n_i);

	typedef enum logic [2:0] {
		PFH_IDLE = 3'b000,
		PFH_WSETUP = 3'b001,
		PFH_WPULSE = 3'b010,
		PFH_WHOLD = 3'b011,
		PFH_READ = 3'b100,
		PFH_GAP = 3'b101,
		PFH_POLL = 3'b110,
		PFH_DONE = 3'b111
	} pfh_state_t;

	localparam logic [5:0] ACC_CYC = 6'(ACCESS_CYC);

	// ----------------------------------------
	// Pin input synchroniser
	// ----------------------------------------
	logic [DATA_W-1:0] din_meta_r;
	logic [DATA_W-1:0] din_sync_r;

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			din_meta_r <= '0;
			din_sync_r <= '0;
		end else begin
			din_meta_r <= byte_lines_i;
			din_sync_r <= din_meta_r;
		end
	end

	// ----------------------------------------
	// Sequence word lookup
	// ----------------------------------------
	pfh_req_t req_r, req_nxt;
	logic [2:0] step_r, step_nxt;
	logic [ADDR_W-1:0] seq_addr;
	logic [DATA_W-1:0] seq_data;

	pfh_seq_rom u_rom (
		.ref_clk_i(ref_clk_i),
		.reset_n_i(reset_n_i),
		.op_i(req_nxt.op),
		.step_i(step_nxt),
		.tgt_addr_i(req_nxt.addr),
		.tgt_data_i(req_nxt.data),
		.addr_o(seq_addr),
		.data_o(seq_data)
	);

	// ----------------------------------------
	// Main state machine
	// ----------------------------------------
	pfh_state_t state_r, state_nxt;
	logic [5:0] cnt_r, cnt_nxt;
	logic [TOUT_W-1:0] tout_r, tout_nxt;
	logic [DATA_W-1:0] last_r, last_nxt;
	logic first_r, first_nxt;
	pfh_ctl_t ctl_nxt;
	logic [ADDR_W-1:0] addr_nxt;
	logic [DATA_W-1:0] dout_nxt;
	logic oe_n_nxt;
	logic ready_nxt;
	logic rsp_valid_nxt;
	pfh_rsp_t rsp_nxt;
	logic [2:0] seq_len;
	logic [TOUT_W-1:0] tout_lim;

	always_comb begin
		seq_len = (req_r.op == PFH_OP_PROGRAM) ? SEQ_LEN_PROGRAM : SEQ_LEN_ERASE;
		case (req_r.op)
			PFH_OP_PROGRAM: tout_lim = TOUT_W'(PROG_TOUT_CYC);
			PFH_OP_CHIP: tout_lim = TOUT_W'(CHIP_TOUT_CYC);
			default: tout_lim = TOUT_W'(ERASE_TOUT_CYC);
		endcase
		state_nxt = state_r;
		req_nxt = req_r;
		step_nxt = step_r;
		cnt_nxt = cnt_r;
		tout_nxt = tout_r;
		last_nxt = last_r;
		first_nxt = first_r;
		ctl_nxt = ctl_o;
		addr_nxt = top_address_line_o;
		dout_nxt = byte_lines_o;
		oe_n_nxt = byte_lines_oe_n_o;
		ready_nxt = 1'b0;
		rsp_valid_nxt = 1'b0;
		rsp_nxt = rsp_o;
		case (state_r)
			PFH_IDLE: begin
				ready_nxt = 1'b1;
				if (req_valid_i && req_ready_o) begin
					ready_nxt = 1'b0;
					req_nxt = req_i;
					step_nxt = '0;
					cnt_nxt = '0;
					if (req_i.op == PFH_OP_READ) begin
						state_nxt = PFH_READ;
						addr_nxt = req_i.addr;
						ctl_nxt = '{ce_n: 1'b0, oe_n: 1'b0, we_n: 1'b1};
						oe_n_nxt = 1'b1;
					end else begin
						state_nxt = PFH_WSETUP;
					end
				end
			end
			PFH_WSETUP: begin
				addr_nxt = seq_addr;
				dout_nxt = seq_data;
				oe_n_nxt = 1'b0;
				ctl_nxt = '{ce_n: 1'b0, oe_n: 1'b1, we_n: 1'b1};
				state_nxt = PFH_WPULSE;
				cnt_nxt = '0;
			end
			PFH_WPULSE: begin
				ctl_nxt = '{ce_n: 1'b0, oe_n: 1'b1, we_n: 1'b0};
				cnt_nxt = cnt_r + 6'h01;
				if (cnt_r == ACC_CYC) begin
					ctl_nxt.we_n = 1'b1;
					cnt_nxt = '0;
					state_nxt = PFH_WHOLD;
				end
			end
			PFH_WHOLD: begin
				ctl_nxt = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
				oe_n_nxt = 1'b1;
				step_nxt = step_r + 3'h1;
				if (step_r + 3'h1 == seq_len) begin
					state_nxt = PFH_GAP;
					tout_nxt = '0;
					first_nxt = 1'b1;
				end else begin
					state_nxt = PFH_WSETUP;
				end
			end
			PFH_READ: begin
				cnt_nxt = cnt_r + 6'h01;
				if (cnt_r == ACC_CYC + 6'h02) begin
					ctl_nxt = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
					rsp_nxt = '{ok: 1'b1, timeout: 1'b0, rdata: din_sync_r};
					state_nxt = PFH_DONE;
				end
			end
			PFH_GAP: begin
				ctl_nxt = '{ce_n: 1'b0, oe_n: 1'b0, we_n: 1'b1};
				cnt_nxt = '0;
				tout_nxt = tout_r + TOUT_W'(1);
				state_nxt = PFH_POLL;
			end
			PFH_POLL: begin
				cnt_nxt = cnt_r + 6'h01;
				tout_nxt = tout_r + TOUT_W'(1);
				if (cnt_r == ACC_CYC + 6'h02) begin
					ctl_nxt = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
					last_nxt = din_sync_r;
					first_nxt = 1'b0;
					if (!first_r && din_sync_r[POLL_BIT] == last_r[POLL_BIT]) begin
						rsp_nxt = '{ok: 1'b1, timeout: 1'b0, rdata: din_sync_r};
						state_nxt = PFH_DONE;
					end else if (tout_r >= tout_lim) begin
						rsp_nxt = '{ok: 1'b0, timeout: 1'b1, rdata: din_sync_r};
						state_nxt = PFH_DONE;
					end else begin
						state_nxt = PFH_GAP;
					end
				end
			end
			PFH_DONE: begin
				rsp_valid_nxt = 1'b1;
				state_nxt = PFH_IDLE;
			end
			default: begin
				state_nxt = PFH_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_r <= PFH_IDLE;
			req_r <= '0;
			step_r <= '0;
			cnt_r <= '0;
			tout_r <= '0;
			last_r <= '0;
			first_r <= 1'b0;
			ctl_o <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
			top_address_line_o <= '0;
			byte_lines_o <= '0;
			byte_lines_oe_n_o <= 1'b1;
			req_ready_o <= 1'b0;
			rsp_valid_o <= 1'b0;
			rsp_o <= '0;
		end else begin
			state_r <= state_nxt;
			req_r <= req_nxt;
			step_r <= step_nxt;
			cnt_r <= cnt_nxt;
			tout_r <= tout_nxt;
			last_r <= last_nxt;
			first_r <= first_nxt;
			ctl_o <= ctl_nxt;
			top_address_line_o <= addr_nxt;
			byte_lines_o <= dout_nxt;
			byte_lines_oe_n_o <= oe_n_nxt;
			req_ready_o <= ready_nxt;
			rsp_valid_o <= rsp_valid_nxt;
			rsp_o <= rsp_nxt;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	no_contention_a: assert property (!byte_lines_oe_n_o |-> ctl_o.oe_n)
		else $error("Host drives byte lines while output gate low");
	strobe_select_a: assert property (
		!ctl_o.we_n |-> !ctl_o.ce_n && !byte_lines_oe_n_o)
		else $error("Write strobe without chip select or data");
	strobe_width_a: assert property ($fell(ctl_o.we_n) |-> !ctl_o.we_n [*3])
		else $error("Write strobe too short");
	data_hold_a: assert property (
		$rose(ctl_o.we_n) |-> !byte_lines_oe_n_o && $stable(byte_lines_o))
		else $error("Data released before strobe rose");
	unlock_first_a: assert property (
		$fell(ctl_o.we_n) && step_r == 3'h0
			|-> byte_lines_o == UNLOCK_DATA1 && top_address_line_o == UNLOCK_ADDR1)
		else $error("First write is not the unlock word");
	sector_addr_a: assert property (
		!ctl_o.we_n && step_r == 3'h5 && req_r.op == PFH_OP_SECTOR
			|-> top_address_line_o[SECTOR_LSB-1:0] == '0 && byte_lines_o == CMD_SECTOR_ERASE)
		else $error("Bad sector erase cycle");
	block_addr_a: assert property (
		!ctl_o.we_n && step_r == 3'h5 && req_r.op == PFH_OP_BLOCK
			|-> top_address_line_o[BLOCK_LSB-1:0] == '0 && byte_lines_o == CMD_BLOCK_ERASE)
		else $error("Bad block erase cycle");
	poll_done_a: assert property (
		state_r == PFH_DONE |=> rsp_valid_o ##1 !rsp_valid_o && req_ready_o)
		else $error("Completion not reported once");
	timeout_bound_a: assert property (
		state_r == PFH_POLL |-> tout_r <= tout_lim + TOUT_W'(ACCESS_CYC + 4))
		else $error("Poll ran past timeout");

endmodule

// *** logic/pfh_pkg.sv ***
// Package for the parallel flash host controller
package pfh_pkg;

	// ----------------------------------------
	// Geometry
	// ----------------------------------------
	localparam int ADDR_W = 20;
	localparam int DATA_W = 8;
	localparam int SECTOR_LSB = 12;
	localparam int BLOCK_LSB = 16;

	// ----------------------------------------
	// Unlock and command codes
	// ----------------------------------------
	localparam logic [19:0] UNLOCK_ADDR1 = 20'h05555;
	localparam logic [19:0] UNLOCK_ADDR2 = 20'h02aaa;
	localparam logic [7:0] UNLOCK_DATA1 = 8'haa;
	localparam logic [7:0] UNLOCK_DATA2 = 8'h55;
	localparam logic [7:0] CMD_PROGRAM = 8'ha0;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
	localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
	localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
	localparam logic [7:0] CMD_BLOCK_ERASE = 8'h50;
	localparam logic [2:0] SEQ_LEN_PROGRAM = 3'h4;
	localparam logic [2:0] SEQ_LEN_ERASE = 3'h6;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_HZ = 40_000_000;
	localparam int ACCESS_NS = 100;
	localparam int ACCESS_CYC = (ACCESS_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int PROGRAM_US = 14;
	localparam int ERASE_MS = 18;
	localparam int CHIP_ERASE_MS = 70;
	localparam int TIMEOUT_FACTOR = 4;
	localparam int PROGRAM_CYC = PROGRAM_US * (CLK_HZ / 1_000_000);
	localparam int ERASE_CYC = ERASE_MS * (CLK_HZ / 1000);
	localparam int CHIP_ERASE_CYC = CHIP_ERASE_MS * (CLK_HZ / 1000);
	localparam int TOUT_W = 26;
	localparam int POLL_BIT = 6;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [2:0] {
		PFH_OP_READ = 3'b000,
		PFH_OP_PROGRAM = 3'b001,
		PFH_OP_SECTOR = 3'b010,
		PFH_OP_BLOCK = 3'b011,
		PFH_OP_CHIP = 3'b100
	} pfh_op_t;

	typedef struct packed {
		pfh_op_t op;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} pfh_req_t;

	typedef struct packed {
		logic ce_n;
		logic oe_n;
		logic we_n;
	} pfh_ctl_t;

	typedef struct packed {
		logic ok;
		logic timeout;
		logic [DATA_W-1:0] rdata;
	} pfh_rsp_t;

endpackage

// *** logic/pfh_seq_rom.sv ***
// Unlock and command word lookup for each write cycle
`timescale 1ns/1ps
module pfh_seq_rom (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	// Lookup
	input wire pfh_pkg::pfh_op_t op_i,
	input wire logic [2:0] step_i,
	input wire logic [pfh_pkg::ADDR_W-1:0] tgt_addr_i,
	input wire logic [pfh_pkg::DATA_W-1:0] tgt_data_i,
	output logic [pfh_pkg::ADDR_W-1:0] addr_o,
	output logic [pfh_pkg::DATA_W-1:0] data_o
);
	import pfh_pkg::*;

	logic [ADDR_W-1:0] addr_nxt;
	logic [DATA_W-1:0] data_nxt;
	logic [ADDR_W-1:0] region;

	always_comb begin
		region = tgt_addr_i;
		if (op_i == PFH_OP_SECTOR) begin
			region[SECTOR_LSB-1:0] = '0;
		end else if (op_i == PFH_OP_BLOCK) begin
			region[BLOCK_LSB-1:0] = '0;
		end
		addr_nxt = UNLOCK_ADDR1;
		data_nxt = UNLOCK_DATA1;
		case (step_i)
			3'h0: begin
				addr_nxt = UNLOCK_ADDR1;
				data_nxt = UNLOCK_DATA1;
			end
			3'h1, 3'h4: begin
				addr_nxt = UNLOCK_ADDR2;
				data_nxt = UNLOCK_DATA2;
			end
			3'h2: begin
				addr_nxt = UNLOCK_ADDR1;
				data_nxt = (op_i == PFH_OP_PROGRAM) ? CMD_PROGRAM : CMD_ERASE_SETUP;
			end
			3'h3: begin
				addr_nxt = (op_i == PFH_OP_PROGRAM) ? tgt_addr_i : UNLOCK_ADDR1;
				data_nxt = (op_i == PFH_OP_PROGRAM) ? tgt_data_i : UNLOCK_DATA1;
			end
			3'h5: begin
				addr_nxt = (op_i == PFH_OP_CHIP) ? UNLOCK_ADDR1 : region;
				case (op_i)
					PFH_OP_SECTOR: data_nxt = CMD_SECTOR_ERASE;
					PFH_OP_BLOCK: data_nxt = CMD_BLOCK_ERASE;
					default: data_nxt = CMD_CHIP_ERASE;
				endcase
			end
			default: begin
				addr_nxt = UNLOCK_ADDR1;
				data_nxt = UNLOCK_DATA1;
			end
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			addr_o <= '0;
			data_o <= '0;
		end else begin
			addr_o <= addr_nxt;
			data_o <= data_nxt;
		end
	end

endmodule

// *** verification/pfh_flash_model.sv ***
// Behavioural model of the parallel flash on the far side of the host
`timescale 1ns/1ps
module pfh_flash_model #(
	parameter int PROG_NS = 14000,
	parameter int ERASE_NS = 18000,
	parameter int CHIP_NS = 70000
) (
	// Flash pins
	input wire pfh_pkg::pfh_ctl_t ctl_i,
	input wire logic [pfh_pkg::ADDR_W-1:0] addr_i,
	input wire logic [pfh_pkg::DATA_W-1:0] bus_i,
	output logic [pfh_pkg::DATA_W-1:0] bus_o,
	output logic drive_o,
	// Test controls
	input wire logic slow_i,
	output logic busy_o
);
	import pfh_pkg::*;
	logic [7:0] mem [0:(1<<ADDR_W)-1];
	logic [7:0] last_r;
	logic [7:0] tgt_r;
	logic tog_r;
	int step;
	wire logic we_n = ctl_i.we_n;
	logic [19:0] seq_a [5] = '{UNLOCK_ADDR1, UNLOCK_ADDR2, UNLOCK_ADDR1, UNLOCK_ADDR1, UNLOCK_ADDR2};
	logic [7:0] seq_d [5] = '{UNLOCK_DATA1, UNLOCK_DATA2, CMD_ERASE_SETUP, UNLOCK_DATA1, UNLOCK_DATA2};
	initial begin
		foreach (mem[i]) mem[i] = 8'hff;
		busy_o = 1'b0;
		tog_r = 1'b0;
		step = 0;
		last_r = 8'h00;
		tgt_r = 8'h00;
	end
	// ----------------------------------------
	// Read side
	// ----------------------------------------
	// Drive only when selected
	assign drive_o = !ctl_i.ce_n && !ctl_i.oe_n && ctl_i.we_n;
	assign bus_o = !drive_o ? ~last_r : busy_o ? {~tgt_r[7], tog_r, 6'h00} : mem[addr_i];
	always @(bus_o or drive_o) begin
		if (drive_o) last_r = bus_o;
	end
	always @(negedge drive_o) begin
		if (busy_o) tog_r = ~tog_r;
	end
	// ----------------------------------------
	// Write side
	// ----------------------------------------
	// Internal durations, eight times longer while slow_i is set
	task automatic run(input int ns, input int lo, input int n, input logic [7:0] d);
		busy_o = 1'b1;
		tgt_r = d;
		#(slow_i ? 8 * ns : ns);
		for (int i = lo; i < lo + n; i++) mem[i] = (n == 1) ? (mem[i] & d) : 8'hff;
		busy_o = 1'b0;
	endtask
	task automatic take(input logic [19:0] a, input logic [7:0] d);
		if (step == 6) begin
			step = 0;
			run(PROG_NS, int'(a), 1, d);
		end else if (step == 5) begin
			step = 0;
			if (d == CMD_SECTOR_ERASE) run(ERASE_NS, int'({a[19:12], 12'h000}), 4096, 8'hff);
			else if (d == CMD_BLOCK_ERASE) run(ERASE_NS, int'({a[19:16], 16'h0000}), 65536, 8'hff);
			else if (d == CMD_CHIP_ERASE && a == UNLOCK_ADDR1) run(CHIP_NS, 0, 1 << 20, 8'hff);
		end else if (step == 2 && a == UNLOCK_ADDR1 && d == CMD_PROGRAM) step = 6;
		else if (a == seq_a[step] && d == seq_d[step]) step = step + 1;
		else step = 0;
	endtask
	always @(negedge we_n) begin
		if (ctl_i.ce_n == 1'b0 && !busy_o) take(addr_i, bus_i);
	end
endmodule

// *** verification/tb.sv ***
// Self-checking bench for the parallel flash host controller
`timescale 1ns/1ps
module tb;
	import pfh_pkg::*;
	typedef struct packed {
		logic chk;
		pfh_rsp_t r;
	} pfh_exp_t;
	localparam int PROG_NS = 14000;
	localparam int ERASE_NS = 18000;
	localparam int CHIP_NS = 70000;
	logic ref_clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic req_valid;
	pfh_req_t req;
	logic req_ready;
	logic rsp_valid;
	pfh_rsp_t rsp;
	pfh_ctl_t ctl;
	logic [19:0] addr;
	logic [7:0] host_d;
	logic host_oe_n;
	logic [7:0] flash_d;
	logic flash_drv;
	logic [7:0] bus;
	logic slow;
	logic busy;
	int mismatches = 0;
	int checked = 0;
	int cycles = 0;
	pfh_exp_t exp_q [$];
	logic [19:0] pa [6] = '{20'h12345, 20'h12fff, 20'h13000, 20'h3abcd, 20'h40000, 20'h80001};
	logic [7:0] pd [6];
	assign bus = (host_oe_n === 1'b0) ? host_d : flash_d;
	pfh_host #(.PROG_TOUT_CYC(4 * PROG_NS / 25), .ERASE_TOUT_CYC(4 * ERASE_NS / 25),
		.CHIP_TOUT_CYC(4 * CHIP_NS / 25)) dut (
		.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .req_valid_i(req_valid), .req_i(req),
		.req_ready_o(req_ready), .rsp_valid_o(rsp_valid), .rsp_o(rsp), .ctl_o(ctl),
		.top_address_line_o(addr), .byte_lines_i(bus), .byte_lines_o(host_d),
		.byte_lines_oe_n_o(host_oe_n));
	pfh_flash_model #(.PROG_NS(PROG_NS), .ERASE_NS(ERASE_NS), .CHIP_NS(CHIP_NS)) flash (
		.ctl_i(ctl), .addr_i(addr), .bus_i(bus), .bus_o(flash_d), .drive_o(flash_drv),
		.slow_i(slow), .busy_o(busy));
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic check(input logic [9:0] seen, input logic [9:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic send(input pfh_op_t op, input logic [19:0] a, input logic [7:0] d,
		input pfh_exp_t e);
		int n;
		n = 0;
		@(posedge ref_clk_i);
		req_valid <= 1'b1;
		req <= '{op: op, addr: a, data: d};
		@(negedge ref_clk_i);
		while (req_ready !== 1'b1 && n < 20000) begin
			@(negedge ref_clk_i);
			n++;
		end
		if (n == 20000) mismatches++;
		@(posedge ref_clk_i);
		exp_q.push_back(e);
		req_valid <= 1'b0;
	endtask
	task automatic rd(input logic [19:0] a, input logic [7:0] v);
		send(PFH_OP_READ, a, 8'h00, '{chk: 1'b1, r: '{ok: 1'b1, timeout: 1'b0, rdata: v}});
	endtask
	task automatic wr(input pfh_op_t op, input logic [19:0] a, input logic [7:0] d,
		input logic to);
		send(op, a, d, '{chk: 1'b0, r: '{ok: !to, timeout: to, rdata: 8'h00}});
	endtask
	// ----------------------------------------
	// Clock, monitor and stimulus
	// ----------------------------------------
	initial begin
		ref_clk_i = 1'b0;
		forever #12.5 ref_clk_i = ~ref_clk_i;
	end
	always @(posedge ref_clk_i) begin
		cycles++;
		if (cycles == 40000) begin
			mismatches++;
			print_verdict();
		end
	end
	always @(negedge ref_clk_i) begin
		pfh_exp_t e;
		if (reset_n_i === 1'b0) check({5'h00, ctl, host_oe_n, req_ready}, 10'h01e);
		if (ctl.we_n === 1'b0) check({8'h00, ctl.ce_n, ctl.oe_n}, 10'h001);
		if (ctl.oe_n === 1'b0 && ctl.ce_n === 1'b0) check({9'h0, host_oe_n}, 10'h001);
		if (rsp_valid === 1'b1) begin
			if (exp_q.size() == 0) begin
				mismatches++;
				$display("unexpected at %0t: seen %h expected none", $time, rsp);
			end else begin
				e = exp_q.pop_front();
				if (e.chk) check({2'b00, rsp.rdata}, {2'b00, e.r.rdata});
				else check({rsp.ok, rsp.timeout, 8'h00}, {e.r.ok, e.r.timeout, 8'h00});
			end
		end
	end
	initial begin
		int n;
		reset_n_i = 1'b0;
		req_valid = 1'b0;
		req = '0;
		slow = 1'b0;
		n = 0;
		void'($urandom(32'ha6687f5b));
		foreach (pd[i]) pd[i] = 8'($urandom) & 8'hfe;
		repeat (5) @(posedge ref_clk_i);
		reset_n_i <= 1'b1;
		rd(20'hfffff, 8'hff);
		for (int i = 0; i < 6; i++) begin
			wr(PFH_OP_PROGRAM, pa[i], pd[i], 1'b0);
			rd(pa[i], pd[i]);
		end
		wr(PFH_OP_SECTOR, 20'h12abc, 8'h00, 1'b0);
		rd(pa[0], 8'hff);
		rd(pa[1], 8'hff);
		rd(pa[2], pd[2]);
		wr(PFH_OP_BLOCK, 20'h3f000, 8'h00, 1'b0);
		rd(pa[3], 8'hff);
		rd(pa[4], pd[4]);
		@(posedge ref_clk_i);
		slow <= 1'b1;
		wr(PFH_OP_PROGRAM, 20'h00010, pd[5], 1'b1);
		while ((exp_q.size() != 0 || busy === 1'b1) && n < 20000) begin
			@(posedge ref_clk_i);
			n++;
		end
		if (n == 20000) mismatches++;
		slow <= 1'b0;
		rd(20'h00010, pd[5]);
		wr(PFH_OP_CHIP, 20'h00000, 8'h00, 1'b0);
		rd(pa[2], 8'hff);
		rd(pa[5], 8'hff);
		n = 0;
		while (exp_q.size() != 0 && n < 20000) begin
			@(posedge ref_clk_i);
			n++;
		end
		// Answers still owed at the end count as failures
		if (exp_q.size() != 0) mismatches++;
		print_verdict();
	end
endmodule
